// File: pkg/dftm_pkg.sv
// Constants and types for the drive fault trip manager.
// Assumes one 50 MHz clock and a synchronous active-low reset.
package dftm_pkg;

  // ****************
  // Error codes
  // ****************
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_OC_CONST = 8'h01;
  localparam logic [7:0] ERR_OC_DECEL = 8'h02;
  localparam logic [7:0] ERR_OC_ACCEL = 8'h03;
  localparam logic [7:0] ERR_OC_OTHER = 8'h04;
  localparam logic [7:0] ERR_OVERLOAD = 8'h05;
  localparam logic [7:0] ERR_OVERVOLT = 8'h07;
  localparam logic [7:0] ERR_MEMORY = 8'h08;
  localparam logic [7:0] ERR_UNDERVOLT = 8'h09;
  localparam logic [7:0] ERR_CPU = 8'h11;
  localparam logic [7:0] ERR_EXTERNAL = 8'h12;
  localparam logic [7:0] ERR_START_GUARD = 8'h13;
  localparam logic [7:0] ERR_GROUND = 8'h14;
  localparam logic [7:0] ERR_IN_OVERVOLT = 8'h15;
  localparam logic [7:0] ERR_THERMAL = 8'h21;
  localparam logic [7:0] ERR_DRIVER = 8'h30;
  localparam logic [7:0] ERR_THERMISTOR = 8'h35;
  localparam logic [7:0] ERR_COMMS = 8'h60;

  // ****************
  // Motion phases
  // ****************
  typedef enum logic [1:0] {
    DFTM_PH_CONST = 2'b00,
    DFTM_PH_DECEL = 2'b01,
    DFTM_PH_ACCEL = 2'b10,
    DFTM_PH_OTHER = 2'b11
  } dftm_phase_t;

  // ****************
  // Timing, widths and history clear select
  // ****************
  localparam longint CLK_HZ = 50000000;
  localparam longint STOP_WAIT_S = 100;
  localparam longint STOP_WAIT_CYC = STOP_WAIT_S * CLK_HZ;
  localparam int WDOG_CYC = 50000;
  localparam int BROWN_RETRY_CYC = 50000;
  localparam int DATA_W = 16;
  localparam int HIST_W = 8 + 3 * DATA_W;
  localparam logic [1:0] HIST_CLEAR_SEL = 2'b00;

endpackage

// File: rtl/dftm_sync.sv
// Two-stage synchroniser for a vector of pin levels.
// Assumes inputs are asynchronous levels.
`timescale 1ns/10ps
module dftm_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // dftm_sync

// File: rtl/dftm_trip_manager.sv
// Fault trip latch, error code, operating data capture and history.
// Assumes fault detectors and keys are pins on no common clock.
`timescale 1ns/10ps
module dftm_trip_manager #(
  parameter longint STOP_WAIT_CYC = dftm_pkg::STOP_WAIT_CYC,
  parameter int WDOG_CYC = dftm_pkg::WDOG_CYC,
  parameter int BROWN_RETRY_CYC = dftm_pkg::BROWN_RETRY_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_over_current,
  input wire logic [1:0] i_motion_phase,
  input wire logic i_overload,
  input wire logic i_bus_over_volt,
  input wire logic i_memory_fault,
  input wire logic i_bus_under_volt,
  input wire logic i_cpu_fault,
  input wire logic i_external_trip_input,
  input wire logic i_unattended_start_guard,
  input wire logic i_run_cmd,
  input wire logic i_power_up_test,
  input wire logic i_ground_fault,
  input wire logic i_input_over_volt,
  input wire logic i_module_hot,
  input wire logic i_driver_fault,
  input wire logic i_thermistor_hot,
  input wire logic i_comm_activity,
  input wire logic i_brown_out,
  input wire logic i_restart_ok,
  input wire logic i_clear_at_power_down,
  input wire logic i_stop_reset_key,
  input wire logic [1:0] i_history_clear_select,
  input wire logic i_init_run,
  input wire logic [dftm_pkg::DATA_W-1:0] i_out_freq,
  input wire logic [dftm_pkg::DATA_W-1:0] i_out_current,
  input wire logic [dftm_pkg::DATA_W-1:0] i_bus_volt,
  output logic o_tripped,
  output logic o_output_enable,
  output logic o_run_allowed,
  output logic [7:0] o_error_code,
  output logic [dftm_pkg::HIST_W-1:0] o_latest_fault_record,
  output logic [dftm_pkg::HIST_W-1:0] o_previous_fault_record,
  output logic [dftm_pkg::HIST_W-1:0] o_oldest_fault_record
);

  // ****************
  // Input synchronisers
  // ****************
  localparam int NS = 25;
  logic [NS-1:0] raw;
  logic [NS-1:0] s;
  assign raw = {i_over_current, i_motion_phase, i_overload, i_bus_over_volt,
                i_memory_fault, i_bus_under_volt, i_cpu_fault,
                i_external_trip_input, i_unattended_start_guard, i_run_cmd,
                i_power_up_test, i_ground_fault, i_input_over_volt,
                i_module_hot, i_driver_fault, i_thermistor_hot,
                i_comm_activity, i_brown_out, i_restart_ok,
                i_clear_at_power_down, i_stop_reset_key,
                i_history_clear_select, i_init_run};

  dftm_sync #(.W(NS)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(raw),
    .o_sync(s)
  );

  // Measurements ride their own two-flop synchroniser, so they line up with the fault
  logic [3*dftm_pkg::DATA_W-1:0] meas;
  dftm_sync #(.W(3 * dftm_pkg::DATA_W)) u_meas_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_out_freq, i_out_current, i_bus_volt}),
    .o_sync(meas)
  );

  logic oc, ovl, bov, mem, buv, cpu, external_trip_input, usg, run, put, gnd, iov;
  logic hot, drv, thm, act, bro, rok, cpd, key, init;
  logic [1:0] ph;
  logic [1:0] hsel;
  assign oc = s[24];
  assign ph = s[23:22];
  assign ovl = s[21];
  assign bov = s[20];
  assign mem = s[19];
  assign buv = s[18];
  assign cpu = s[17];
  assign external_trip_input = s[16];
  assign usg = s[15];
  assign run = s[14];
  assign put = s[13];
  assign gnd = s[12];
  assign iov = s[11];
  assign hot = s[10];
  assign drv = s[9];
  assign thm = s[8];
  assign act = s[7];
  assign bro = s[6];
  assign rok = s[5];
  assign cpd = s[4];
  assign key = s[3];
  assign hsel = s[2:1];
  assign init = s[0];

  // ****************
  // Power-up window
  // ****************
  // First cycle after reset release is the power-on instant
  logic first_q;
  logic act_q;
  logic init_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      first_q <= 1'b1;
      act_q <= 1'b0;
      init_q <= 1'b0;
    end else begin
      first_q <= 1'b0;
      act_q <= act;
      init_q <= init;
    end
  end

  // Synchroniser delay: power-on sampling happens two cycles late
  logic [1:0] pwr_q;
  logic pwr_now;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pwr_q <= 2'b00;
    end else begin
      pwr_q <= {pwr_q[0], first_q};
    end
  end
  assign pwr_now = pwr_q[1];

  // ****************
  // Stop-mode timer
  // ****************
  logic [32:0] stop_cnt_q;
  logic stop_long;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stop_cnt_q <= '0;
    end else if (run) begin
      stop_cnt_q <= '0;
    end else if (stop_cnt_q < 33'(STOP_WAIT_CYC)) begin
      stop_cnt_q <= stop_cnt_q + 33'd1;
    end
  end
  assign stop_long = (stop_cnt_q >= 33'(STOP_WAIT_CYC));

  // ****************
  // Comms watchdog
  // ****************
  logic [31:0] wd_cnt_q;
  logic wd_expired;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wd_cnt_q <= '0;
    end else if (act != act_q) begin
      wd_cnt_q <= '0;
    end else if (wd_cnt_q < 32'(WDOG_CYC)) begin
      wd_cnt_q <= wd_cnt_q + 32'd1;
    end
  end
  assign wd_expired = (wd_cnt_q >= 32'(WDOG_CYC));

  // ****************
  // Brown-out restart
  // ****************
  logic brown_q;
  logic [31:0] br_cnt_q;
  logic brown_fail;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      brown_q <= 1'b0;
      br_cnt_q <= '0;
    end else if (bro) begin
      brown_q <= 1'b1;
      br_cnt_q <= '0;
    end else if (brown_q && (rok || br_cnt_q >= 32'(BROWN_RETRY_CYC))) begin
      // Give up once the window runs out, else the failure would re-trip forever
      brown_q <= 1'b0;
    end else if (brown_q && br_cnt_q < 32'(BROWN_RETRY_CYC)) begin
      br_cnt_q <= br_cnt_q + 32'd1;
    end
  end
  assign brown_fail = brown_q && !rok && (br_cnt_q >= 32'(BROWN_RETRY_CYC));

  // ****************
  // Fault priority
  // ****************
  logic [7:0] code_d;
  always_comb begin
    code_d = dftm_pkg::ERR_NONE;
    if (oc) begin
      case (dftm_pkg::dftm_phase_t'(ph))
        dftm_pkg::DFTM_PH_CONST: code_d = dftm_pkg::ERR_OC_CONST;
        dftm_pkg::DFTM_PH_DECEL: code_d = dftm_pkg::ERR_OC_DECEL;
        dftm_pkg::DFTM_PH_ACCEL: code_d = dftm_pkg::ERR_OC_ACCEL;
        default: code_d = dftm_pkg::ERR_OC_OTHER;
      endcase
    end else if (ovl) begin
      code_d = dftm_pkg::ERR_OVERLOAD;
    end else if (bov) begin
      code_d = dftm_pkg::ERR_OVERVOLT;
    end else if (mem || (pwr_now && cpd)) begin
      code_d = dftm_pkg::ERR_MEMORY;
    end else if (buv || brown_fail) begin
      code_d = dftm_pkg::ERR_UNDERVOLT;
    end else if (cpu) begin
      code_d = dftm_pkg::ERR_CPU;
    end else if (external_trip_input) begin
      code_d = dftm_pkg::ERR_EXTERNAL;
    end else if (pwr_now && usg && run) begin
      code_d = dftm_pkg::ERR_START_GUARD;
    end else if (put && gnd) begin
      code_d = dftm_pkg::ERR_GROUND;
    end else if (stop_long && iov) begin
      code_d = dftm_pkg::ERR_IN_OVERVOLT;
    end else if (hot) begin
      code_d = dftm_pkg::ERR_THERMAL;
    end else if (drv) begin
      code_d = dftm_pkg::ERR_DRIVER;
    end else if (thm) begin
      code_d = dftm_pkg::ERR_THERMISTOR;
    end else if (wd_expired) begin
      code_d = dftm_pkg::ERR_COMMS;
    end
  end

  // ****************
  // Trip latch
  // ****************
  logic trip_new;
  assign trip_new = !o_tripped && (code_d != dftm_pkg::ERR_NONE);

  // First fault wins; later faults ignored until cleared
  // Latch code, output off
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_tripped <= 1'b0;
      o_error_code <= dftm_pkg::ERR_NONE;
    end else if (trip_new) begin
      o_tripped <= 1'b1;
      o_error_code <= code_d;
    end else if (o_tripped && key) begin
      o_tripped <= 1'b0;
      o_error_code <= dftm_pkg::ERR_NONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_output_enable <= 1'b0;
      o_run_allowed <= 1'b0;
    end else begin
      o_run_allowed <= !o_tripped && !trip_new;
      o_output_enable <= !o_tripped && !trip_new && !brown_q && !bro && run;
    end
  end

  // ****************
  // Fault history
  // ****************
  logic [dftm_pkg::HIST_W-1:0] rec_d;
  logic hist_clr;
  assign rec_d = {code_d, meas};
  assign hist_clr = init && !init_q && (hsel == dftm_pkg::HIST_CLEAR_SEL);

  // A trip in the clear cycle is kept: the new record wins
  // Shift and write latest
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_latest_fault_record <= '0;
      o_previous_fault_record <= '0;
      o_oldest_fault_record <= '0;
    end else if (trip_new) begin
      o_latest_fault_record <= rec_d;
      o_previous_fault_record <= hist_clr ? '0 : o_latest_fault_record;
      o_oldest_fault_record <= hist_clr ? '0 : o_previous_fault_record;
    end else if (hist_clr) begin
      o_latest_fault_record <= '0;
      o_previous_fault_record <= '0;
      o_oldest_fault_record <= '0;
    end
  end

endmodule // dftm_trip_manager

// File: tb/dftm_partner.sv
// Far side model: power stage measurements and link traffic.
// Assumes the bench gates link traffic through i_comm_en.
`timescale 1ns/10ps
module dftm_partner #(
  parameter logic [15:0] FREQ = 16'h0321,
  parameter logic [15:0] CUR = 16'h0456,
  parameter logic [15:0] BUSV = 16'h0789
) (
  input wire logic i_clk,
  input wire logic i_comm_en,
  output logic o_comm_activity,
  output logic [15:0] o_out_freq,
  output logic [15:0] o_out_current,
  output logic [15:0] o_bus_volt
);
  // ****************
  // Behaviour
  // ****************
  logic [2:0] cnt_q = 3'h0;
  initial o_comm_activity = 1'b0;
  // Held steady, so the words cross the synchroniser intact
  assign o_out_freq = FREQ;
  assign o_out_current = CUR;
  assign o_bus_volt = BUSV;
  // Toggle every 8 cycles, well inside the watchdog time
  always @(negedge i_clk) begin
    cnt_q <= cnt_q + 3'h1;
    if (i_comm_en && cnt_q == 3'h0) o_comm_activity <= !o_comm_activity;
  end
endmodule // dftm_partner

// File: tb/dftm_chk.sv
// Port checker for the trip manager.
// Assumes it is bound to dftm_trip_manager.
`timescale 1ns/10ps
module dftm_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_over_current,
  input wire logic [1:0] i_motion_phase,
  input wire logic i_stop_reset_key,
  input wire logic o_tripped,
  input wire logic o_output_enable,
  input wire logic o_run_allowed,
  input wire logic [7:0] o_error_code,
  input wire logic [dftm_pkg::HIST_W-1:0] o_latest_fault_record,
  input wire logic [dftm_pkg::HIST_W-1:0] o_previous_fault_record,
  input wire logic [dftm_pkg::HIST_W-1:0] o_oldest_fault_record
);
  // ****************
  // Assertions
  // ****************
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  off_when_trip_a: assert property (o_tripped |-> !o_output_enable)
    else $error("output on while tripped");
  code_shown_a: assert property (o_tripped |-> o_error_code != 8'h00)
    else $error("trip without code");
  code_hold_a: assert property (o_tripped && $past(o_tripped) |-> $stable(o_error_code))
    else $error("code changed during trip");
  oc_phase_a: assert property ($rose(o_tripped) && $past(i_over_current, 2)
    |-> o_error_code == {6'h00, $past(i_motion_phase, 2)} + 8'h01)
    else $error("over-current code wrong for phase");
  hist_shift_a: assert property ($rose(o_tripped)
    |-> o_previous_fault_record == $past(o_latest_fault_record)
    && o_oldest_fault_record == $past(o_previous_fault_record))
    else $error("history did not shift");
  latest_code_a: assert property ($rose(o_tripped)
    |-> o_latest_fault_record[dftm_pkg::HIST_W-1 -: 8] == o_error_code)
    else $error("latest record code differs");
  clear_key_a: assert property ($fell(o_tripped) |-> $past(i_stop_reset_key, 2))
    else $error("trip cleared without key");
  run_block_a: assert property (o_tripped |-> !o_run_allowed)
    else $error("run allowed while tripped");
endmodule // dftm_chk

bind dftm_trip_manager dftm_chk dftm_chk_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_over_current(i_over_current), .i_motion_phase(i_motion_phase),
  .i_stop_reset_key(i_stop_reset_key), .o_tripped(o_tripped),
  .o_output_enable(o_output_enable), .o_run_allowed(o_run_allowed),
  .o_error_code(o_error_code), .o_latest_fault_record(o_latest_fault_record),
  .o_previous_fault_record(o_previous_fault_record),
  .o_oldest_fault_record(o_oldest_fault_record));

// File: tb/tb_drive_fault_trip_manager.sv
// Self-checking bench for the trip manager.
// Assumes short counts: stop wait 200, watchdog 50, retry 20 cycles.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_drive_fault_trip_manager;
  // ****************
  // Signals
  // ****************
  localparam logic [15:0] FQ = 16'h0321, CU = 16'h0456, BV = 16'h0789;
  localparam logic [103:0] CODES = {dftm_pkg::ERR_THERMISTOR, dftm_pkg::ERR_DRIVER,
    dftm_pkg::ERR_THERMAL, dftm_pkg::ERR_EXTERNAL, dftm_pkg::ERR_CPU, dftm_pkg::ERR_UNDERVOLT,
    dftm_pkg::ERR_MEMORY, dftm_pkg::ERR_OVERVOLT, dftm_pkg::ERR_OVERLOAD, dftm_pkg::ERR_OC_OTHER,
    dftm_pkg::ERR_OC_ACCEL, dftm_pkg::ERR_OC_DECEL, dftm_pkg::ERR_OC_CONST};
  logic clk, rst_n, oc, guard, run, put, gnd, iov, comm_en, comm, bro, rok, cpd, key, init;
  logic [1:0] ph, hsel;
  logic [8:0] flt;
  logic [15:0] freq, cur, busv;
  logic tripped, oe, rall;
  logic [7:0] code;
  logic [55:0] lat, prv, old;
  int bad_count, n_compared;
  always #10 clk = ~clk;
  dftm_partner #(.FREQ(FQ), .CUR(CU), .BUSV(BV)) dftm_partner_inst (.i_clk(clk),
    .i_comm_en(comm_en), .o_comm_activity(comm), .o_out_freq(freq), .o_out_current(cur),
    .o_bus_volt(busv));
  dftm_trip_manager #(.STOP_WAIT_CYC(200), .WDOG_CYC(50), .BROWN_RETRY_CYC(20))
    dftm_trip_manager_inst (.i_clk(clk), .i_rst_n(rst_n), .i_over_current(oc),
    .i_motion_phase(ph), .i_overload(flt[0]), .i_bus_over_volt(flt[1]),
    .i_memory_fault(flt[2]), .i_bus_under_volt(flt[3]), .i_cpu_fault(flt[4]),
    .i_external_trip_input(flt[5]), .i_unattended_start_guard(guard), .i_run_cmd(run),
    .i_power_up_test(put), .i_ground_fault(gnd), .i_input_over_volt(iov),
    .i_module_hot(flt[6]), .i_driver_fault(flt[7]), .i_thermistor_hot(flt[8]),
    .i_comm_activity(comm), .i_brown_out(bro), .i_restart_ok(rok),
    .i_clear_at_power_down(cpd), .i_stop_reset_key(key), .i_history_clear_select(hsel),
    .i_init_run(init), .i_out_freq(freq), .i_out_current(cur), .i_bus_volt(busv),
    .o_tripped(tripped), .o_output_enable(oe), .o_run_allowed(rall), .o_error_code(code),
    .o_latest_fault_record(lat), .o_previous_fault_record(prv), .o_oldest_fault_record(old));
  // ****************
  // Shared tasks
  // ****************
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clk) rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
  endtask
  // Bounded wait; a hang ends the run
  task automatic wait_trip(input logic [7:0] c);
    int n;
    n = 0;
    while (tripped !== 1'b1 && n < 400) begin @(negedge clk); n++; end
    if (n >= 400) begin bad_count++; $display("unexpected timeout exp %h got %h", c, code);
      finish_test(); end
    `CHK("error_code", c, code)
    `CHK("output_enable", 1'b0, oe)
    `CHK("latest_record", {c, FQ, CU, BV}, lat)
  endtask
  task automatic clr();
    @(negedge clk) flt = 9'h000; oc = 1'b0; gnd = 1'b0; iov = 1'b0; bro = 1'b0; key = 1'b1;
    repeat (6) @(negedge clk);
    key = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("tripped", 1'b0, tripped)
  endtask
  task automatic trip_clr(input int b, input logic [7:0] c);
    @(negedge clk) flt[b] = 1'b1;
    wait_trip(c);
    clr();
  endtask
  task automatic init_pulse(input logic [1:0] s);
    @(negedge clk) hsel = s; init = 1'b1;
    repeat (4) @(negedge clk);
    init = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic sc_faults();
    for (int i = 0; i < 13; i++) begin
      @(negedge clk);
      `CHK("output_enable", 1'b1, oe)
      if (i < 4) begin oc = 1'b1; ph = i[1:0]; end
      else flt[i-4] = 1'b1;
      wait_trip(CODES[i*8 +: 8]);
      clr();
    end
  endtask
  task automatic sc_prio();
    logic [55:0] p;
    @(negedge clk) flt = 9'h111;
    wait_trip(dftm_pkg::ERR_OVERLOAD);
    p = prv;
    flt[5] = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("prev_kept", p, prv)
    `CHK("code_kept", dftm_pkg::ERR_OVERLOAD, code)
    clr();
  endtask
  task automatic sc_hist();
    trip_clr(0, dftm_pkg::ERR_OVERLOAD);
    trip_clr(4, dftm_pkg::ERR_CPU);
    trip_clr(8, dftm_pkg::ERR_THERMISTOR);
    `CHK("latest", dftm_pkg::ERR_THERMISTOR, lat[55:48])
    `CHK("previous", dftm_pkg::ERR_CPU, prv[55:48])
    `CHK("oldest", dftm_pkg::ERR_OVERLOAD, old[55:48])
    init_pulse(2'h1);
    `CHK("kept_previous", dftm_pkg::ERR_CPU, prv[55:48])
    init_pulse(2'h0);
    `CHK("cleared", 168'h0, {lat, prv, old})
    trip_clr(1, dftm_pkg::ERR_OVERVOLT);
    `CHK("empty_previous", 56'h0, prv)
    hsel = 2'h1;
  endtask
  task automatic sc_brown();
    @(negedge clk) bro = 1'b1; rok = 1'b1;
    repeat (6) @(negedge clk);
    `CHK("brown_off", 1'b0, oe)
    repeat (40) @(negedge clk);
    `CHK("restart_no_trip", 1'b0, tripped)
    bro = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("restart_on", 1'b1, oe)
    bro = 1'b1; rok = 1'b0;
    repeat (6) @(negedge clk);
    bro = 1'b0;
    wait_trip(dftm_pkg::ERR_UNDERVOLT);
    clr();
  endtask
  task automatic sc_misc();
    @(negedge clk) comm_en = 1'b0;
    wait_trip(dftm_pkg::ERR_COMMS);
    comm_en = 1'b1;
    repeat (20) @(negedge clk);
    clr();
    run = 1'b0; iov = 1'b1;
    repeat (150) @(negedge clk);
    `CHK("early_input_ov", 1'b0, tripped)
    wait_trip(dftm_pkg::ERR_IN_OVERVOLT);
    clr();
    run = 1'b1;
    repeat (6) @(negedge clk);
    `CHK("run_again", 1'b1, rall)
    gnd = 1'b1;
    repeat (10) @(negedge clk);
    `CHK("ground_outside", 1'b0, tripped)
    put = 1'b1;
    wait_trip(dftm_pkg::ERR_GROUND);
    put = 1'b0;
    clr();
  endtask
  task automatic sc_power();
    @(negedge clk) guard = 1'b1;
    do_reset();
    wait_trip(dftm_pkg::ERR_START_GUARD);
    `CHK("run_refused", 1'b0, rall)
    guard = 1'b0; run = 1'b0;
    clr();
    run = 1'b1; cpd = 1'b1;
    do_reset();
    wait_trip(dftm_pkg::ERR_MEMORY);
    cpd = 1'b0;
    clr();
  endtask
  initial begin
    clk = 1'b0; rst_n = 1'b0; oc = 1'b0; ph = 2'h0; flt = 9'h000; guard = 1'b0; run = 1'b1;
    put = 1'b0; gnd = 1'b0; iov = 1'b0; comm_en = 1'b1; bro = 1'b0; rok = 1'b0; cpd = 1'b0;
    key = 1'b0; hsel = 2'h1; init = 1'b0; bad_count = 0; n_compared = 0;
    do_reset();
    repeat (6) @(negedge clk);
    sc_faults();
    sc_prio();
    sc_hist();
    sc_brown();
    sc_misc();
    sc_power();
    finish_test();
  end
endmodule // tb_drive_fault_trip_manager
